// ===== src/apss_map.svh
`ifndef APSS_MAP_SVH
`define APSS_MAP_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses, one word each)
// ----------------------------------------------------------------
`define APSS_OFF_CTRL     8'h00
`define APSS_OFF_PICK     8'h04
`define APSS_OFF_INCL     8'h08
`define APSS_OFF_EDIT_IDX 8'h0C
`define APSS_OFF_LIVE_IDX 8'h10
`define APSS_OFF_LEN      8'h14
`define APSS_OFF_RESTART  8'h18
`define APSS_OFF_SHADE    8'h1C
`define APSS_OFF_GAIN     8'h20
`define APSS_OFF_EXP      8'h24
`define APSS_OFF_PROFILE  8'h28

// ----------------------------------------------------------------
// Field positions and values
// ----------------------------------------------------------------
`define APSS_CTRL_CYC_BIT  0
`define APSS_CTRL_EDIT_BIT 1
`define APSS_RESTART_BIT   0
`define APSS_INCL_BIT      0
`define APSS_DEF_SHADE     32'h0000_0000
`define APSS_DEF_GAIN      32'h0000_0001
`define APSS_DEF_EXP       32'h0000_2710
`define APSS_LEN_MIN       32'h0000_0001
`define APSS_LEN_RST       32'h0000_0020
`define APSS_INCL_ALL      3'h7
`endif

// ===== src/apss_pkg.sv
package apss_pkg;

    // Kind codes double as bit positions of the include and write masks.
    typedef enum logic [1:0] {
        APSS_KIND_SHADE = 2'h0,
        APSS_KIND_GAIN  = 2'h1,
        APSS_KIND_EXP   = 2'h2
    } apss_kind_t;

    typedef enum logic [2:0] {
        APSS_LD_START = 3'b001,
        APSS_LD_REQ   = 3'b010,
        APSS_LD_DONE  = 3'b100
    } apss_ld_state_t;

endpackage

// ===== src/apss_restore.sv
module apss_restore #(
    parameter int SETS  = 32,
    parameter int IDX_W = 5
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [1:0]       boot_profile_i,
    input  wire logic             nv_valid_i,
    output logic                  nv_req_o,
    output logic      [1:0]       nv_profile_o,
    output logic      [IDX_W-1:0] nv_index_o,
    output logic                  wr_en_o,
    output logic                  busy_o
);

    apss_pkg::apss_ld_state_t state_q;
    logic                     last_w;

    assign last_w  = nv_index_o == IDX_W'(SETS - 1);
    assign wr_en_o = (state_q == apss_pkg::APSS_LD_REQ) && nv_valid_i;
    assign busy_o  = state_q != apss_pkg::APSS_LD_DONE;

    // The profile is caught one edge after reset release, never under reset.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= apss_pkg::APSS_LD_START;
        end else begin
            unique case (state_q)
                apss_pkg::APSS_LD_START: state_q <= apss_pkg::APSS_LD_REQ;
                apss_pkg::APSS_LD_REQ: if (wr_en_o && last_w) state_q <= apss_pkg::APSS_LD_DONE;
                apss_pkg::APSS_LD_DONE: state_q <= apss_pkg::APSS_LD_DONE;
                default: state_q <= apss_pkg::APSS_LD_START;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nv_req_o     <= 1'b0;
            nv_index_o   <= '0;
            nv_profile_o <= 2'h0;
        end else if (state_q == apss_pkg::APSS_LD_START) begin
            nv_req_o     <= 1'b1;
            nv_profile_o <= boot_profile_i;
        end else if (wr_en_o) begin
            nv_req_o   <= !last_w;
            nv_index_o <= nv_index_o + IDX_W'(1);
        end
    end

    AST_RESTORE_START: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(rst_i) |-> ##1 (nv_req_o && nv_index_o == '0))
        else $error("restore did not start after reset");

endmodule

// ===== src/apss_set_store.sv
`include "apss_map.svh"

module apss_set_store #(
    parameter int SETS    = 32,
    parameter int IDX_W   = 5,
    parameter int SHADE_W = 4,
    parameter int GAIN_W  = 8,
    parameter int EXP_W   = 24
) (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               wr_en_i,
    input  wire logic [IDX_W-1:0]   wr_idx_i,
    input  wire logic [2:0]         wr_mask_i,
    input  wire logic [SHADE_W-1:0] wr_shade_i,
    input  wire logic [GAIN_W-1:0]  wr_gain_i,
    input  wire logic [EXP_W-1:0]   wr_exp_i,
    input  wire logic [IDX_W-1:0]   rd_a_idx_i,
    input  wire logic [IDX_W-1:0]   rd_b_idx_i,
    output logic      [SHADE_W-1:0] rd_a_shade_o,
    output logic      [GAIN_W-1:0]  rd_a_gain_o,
    output logic      [EXP_W-1:0]   rd_a_exp_o,
    output logic      [SHADE_W-1:0] rd_b_shade_o,
    output logic      [GAIN_W-1:0]  rd_b_gain_o,
    output logic      [EXP_W-1:0]   rd_b_exp_o
);

    logic [SHADE_W-1:0] shade_q [SETS];
    logic [GAIN_W-1:0]  gain_q  [SETS];
    logic [EXP_W-1:0]   exp_q   [SETS];

    always_ff @(posedge clk_i) begin
        for (int i = 0; i < SETS; i++) begin
            if (rst_i) begin
                shade_q[i] <= SHADE_W'(`APSS_DEF_SHADE);
                gain_q[i]  <= GAIN_W'(`APSS_DEF_GAIN);
                exp_q[i]   <= EXP_W'(`APSS_DEF_EXP);
            end else if (wr_en_i && wr_idx_i == IDX_W'(i)) begin
                if (wr_mask_i[apss_pkg::APSS_KIND_SHADE]) shade_q[i] <= wr_shade_i;
                if (wr_mask_i[apss_pkg::APSS_KIND_GAIN]) gain_q[i] <= wr_gain_i;
                if (wr_mask_i[apss_pkg::APSS_KIND_EXP]) exp_q[i] <= wr_exp_i;
            end
        end
    end

    assign rd_a_shade_o = shade_q[rd_a_idx_i];
    assign rd_a_gain_o  = gain_q[rd_a_idx_i];
    assign rd_a_exp_o   = exp_q[rd_a_idx_i];
    assign rd_b_shade_o = shade_q[rd_b_idx_i];
    assign rd_b_gain_o  = gain_q[rd_b_idx_i];
    assign rd_b_exp_o   = exp_q[rd_b_idx_i];

endmodule

// ===== src/apss_top.sv
// The implementer's own choices: the register addresses and the Wishbone interface to the registers.
`include "apss_map.svh"

module apss_top #(
    parameter int SETS    = 32,
    parameter int IDX_W   = 5,
    parameter int LEN_W   = 6,
    parameter int SHADE_W = 4,
    parameter int GAIN_W  = 8,
    parameter int EXP_W   = 24
) (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [7:0]         wb_adr_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic [31:0]        wb_dat_i,
    output logic      [31:0]        wb_dat_o,
    output logic                    wb_ack_o,
    input  wire logic               exposure_start_i,
    input  wire logic               frame_req_i,
    input  wire logic [1:0]         boot_profile_i,
    input  wire logic               nv_valid_i,
    input  wire logic [SHADE_W-1:0] nv_shade_i,
    input  wire logic [GAIN_W-1:0]  nv_gain_i,
    input  wire logic [EXP_W-1:0]   nv_exp_i,
    output logic                    nv_req_o,
    output logic      [1:0]         nv_profile_o,
    output logic      [IDX_W-1:0]   nv_index_o,
    output logic      [SHADE_W-1:0] shading_o,
    output logic      [GAIN_W-1:0]  gain_o,
    output logic      [EXP_W-1:0]   exposure_o,
    output logic      [IDX_W-1:0]   live_index_o
);

    // ----------------------------------------------------------------
    // Control state
    // ----------------------------------------------------------------
    logic                 cyc_en_q;
    logic                 edit_q;
    apss_pkg::apss_kind_t pick_q;
    logic [2:0]           incl_q;
    logic [IDX_W-1:0]     edit_idx_q;
    logic [LEN_W-1:0]     len_q;
    logic [SHADE_W-1:0]   live_shade_q;
    logic [GAIN_W-1:0]    live_gain_q;
    logic [EXP_W-1:0]     live_exp_q;
    logic [SHADE_W-1:0]   pend_shade_q;
    logic [GAIN_W-1:0]    pend_gain_q;

    logic [31:0]          rd_word;
    logic [31:0]          wval;
    logic                 wr_go;
    logic                 edit_enter;
    logic                 restart_go;
    logic                 ld_wr;
    logic                 ld_busy;
    logic                 st_en;
    logic [IDX_W-1:0]     st_idx;
    logic [2:0]           st_mask;
    logic [SHADE_W-1:0]   st_shade;
    logic [GAIN_W-1:0]    st_gain;
    logic [EXP_W-1:0]     st_exp;
    logic [SHADE_W-1:0]   a_shade;
    logic [GAIN_W-1:0]    a_gain;
    logic [EXP_W-1:0]     a_exp;
    logic [SHADE_W-1:0]   b_shade;
    logic [GAIN_W-1:0]    b_gain;
    logic [EXP_W-1:0]     b_exp;
    logic [SHADE_W-1:0]   eff_shade;
    logic [GAIN_W-1:0]    eff_gain;
    logic [EXP_W-1:0]     eff_exp;
    logic [LEN_W-1:0]     len_new;

    // ----------------------------------------------------------------
    // Bus decode helpers
    // ----------------------------------------------------------------
    function automatic logic wr_at(input logic [7:0] off);
        return wr_go && wb_adr_i == off;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) r[b*8 +: 8] = nw[b*8 +: 8];
        end
        return r;
    endfunction

    // A write lands at the edge where the master samples ack high.
    assign wr_go      = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    assign wval       = merge(rd_word, wb_dat_i, wb_sel_i);
    assign edit_enter = wr_at(`APSS_OFF_CTRL) && wval[`APSS_CTRL_EDIT_BIT] && !edit_q;
    assign restart_go = wr_at(`APSS_OFF_RESTART) && wval[`APSS_RESTART_BIT];
    assign len_new    = wval[LEN_W-1:0];

    // ----------------------------------------------------------------
    // Read-back
    // ----------------------------------------------------------------
    always_comb begin
        rd_word = 32'h0000_0000;
        case (wb_adr_i)
            `APSS_OFF_CTRL: begin
                rd_word[`APSS_CTRL_CYC_BIT]  = cyc_en_q;
                rd_word[`APSS_CTRL_EDIT_BIT] = edit_q;
            end
            `APSS_OFF_PICK:     rd_word[1:0] = pick_q;
            `APSS_OFF_INCL:     rd_word[`APSS_INCL_BIT] = incl_q[pick_q];
            `APSS_OFF_EDIT_IDX: rd_word[IDX_W-1:0] = edit_idx_q;
            `APSS_OFF_LIVE_IDX: rd_word[IDX_W-1:0] = live_index_o;
            `APSS_OFF_LEN:      rd_word[LEN_W-1:0] = len_q;
            `APSS_OFF_SHADE:    rd_word[SHADE_W-1:0] = edit_q ? b_shade : live_shade_q;
            `APSS_OFF_GAIN:     rd_word[GAIN_W-1:0] = edit_q ? b_gain : live_gain_q;
            `APSS_OFF_EXP:      rd_word[EXP_W-1:0] = edit_q ? b_exp : live_exp_q;
            `APSS_OFF_PROFILE:  rd_word[1:0] = nv_profile_o;
            default:            rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            wb_dat_o <= (wb_cyc_i && wb_stb_i && !wb_ack_o) ? rd_word : 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // Software-written controls
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cyc_en_q <= 1'b0;
            edit_q   <= 1'b0;
        end else if (wr_at(`APSS_OFF_CTRL)) begin
            cyc_en_q <= wval[`APSS_CTRL_CYC_BIT];
            edit_q   <= wval[`APSS_CTRL_EDIT_BIT];
        end
    end

    // Code 3 names no kind, so such a pick is ignored.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pick_q <= apss_pkg::APSS_KIND_SHADE;
        end else if (wr_at(`APSS_OFF_PICK) && wval[1:0] <= apss_pkg::APSS_KIND_EXP) begin
            pick_q <= apss_pkg::apss_kind_t'(wval[1:0]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            incl_q <= `APSS_INCL_ALL;
        end else if (edit_enter) begin
            incl_q <= `APSS_INCL_ALL;
        end else if (wr_at(`APSS_OFF_INCL)) begin
            incl_q[pick_q] <= wval[`APSS_INCL_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            edit_idx_q <= '0;
        end else if (wr_at(`APSS_OFF_EDIT_IDX)) begin
            edit_idx_q <= wval[IDX_W-1:0];
        end
    end

    // Out-of-range lengths are dropped so the cycle never runs empty.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            len_q <= LEN_W'(`APSS_LEN_RST);
        end else if (wr_at(`APSS_OFF_LEN) && wval[31:LEN_W] == '0 && len_new >= LEN_W'(`APSS_LEN_MIN)
                     && len_new <= LEN_W'(SETS)) begin
            len_q <= len_new;
        end
    end

    // Live values take writes only for kinds not captured by the edit mode.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            live_shade_q <= SHADE_W'(`APSS_DEF_SHADE);
            live_gain_q  <= GAIN_W'(`APSS_DEF_GAIN);
            live_exp_q   <= EXP_W'(`APSS_DEF_EXP);
        end else begin
            if (wr_at(`APSS_OFF_SHADE) && !(edit_q && incl_q[apss_pkg::APSS_KIND_SHADE]))
                live_shade_q <= wval[SHADE_W-1:0];
            if (wr_at(`APSS_OFF_GAIN) && !(edit_q && incl_q[apss_pkg::APSS_KIND_GAIN]))
                live_gain_q <= wval[GAIN_W-1:0];
            if (wr_at(`APSS_OFF_EXP) && !(edit_q && incl_q[apss_pkg::APSS_KIND_EXP]))
                live_exp_q <= wval[EXP_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // Set storage and restore after reset
    // ----------------------------------------------------------------
    always_comb begin
        st_en    = ld_wr;
        st_idx   = nv_index_o;
        st_mask  = `APSS_INCL_ALL;
        st_shade = nv_shade_i;
        st_gain  = nv_gain_i;
        st_exp   = nv_exp_i;
        if (!ld_busy) begin
            st_idx = edit_idx_q;
            if (edit_enter) begin
                st_en    = 1'b1;
                st_shade = SHADE_W'(`APSS_DEF_SHADE);
                st_gain  = GAIN_W'(`APSS_DEF_GAIN);
                st_exp   = EXP_W'(`APSS_DEF_EXP);
            end else begin
                st_mask[apss_pkg::APSS_KIND_SHADE] = wr_at(`APSS_OFF_SHADE) && incl_q[apss_pkg::APSS_KIND_SHADE];
                st_mask[apss_pkg::APSS_KIND_GAIN]  = wr_at(`APSS_OFF_GAIN) && incl_q[apss_pkg::APSS_KIND_GAIN];
                st_mask[apss_pkg::APSS_KIND_EXP]   = wr_at(`APSS_OFF_EXP) && incl_q[apss_pkg::APSS_KIND_EXP];
                st_en    = edit_q && |st_mask;
                st_shade = wval[SHADE_W-1:0];
                st_gain  = wval[GAIN_W-1:0];
                st_exp   = wval[EXP_W-1:0];
            end
        end
    end

    apss_set_store #(
        .SETS    (SETS),
        .IDX_W   (IDX_W),
        .SHADE_W (SHADE_W),
        .GAIN_W  (GAIN_W),
        .EXP_W   (EXP_W)
    ) u_store (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .wr_en_i      (st_en),
        .wr_idx_i     (st_idx),
        .wr_mask_i    (st_mask),
        .wr_shade_i   (st_shade),
        .wr_gain_i    (st_gain),
        .wr_exp_i     (st_exp),
        .rd_a_idx_i   (live_index_o),
        .rd_b_idx_i   (edit_idx_q),
        .rd_a_shade_o (a_shade),
        .rd_a_gain_o  (a_gain),
        .rd_a_exp_o   (a_exp),
        .rd_b_shade_o (b_shade),
        .rd_b_gain_o  (b_gain),
        .rd_b_exp_o   (b_exp)
    );

    apss_restore #(
        .SETS  (SETS),
        .IDX_W (IDX_W)
    ) u_restore (
        .clk_i          (clk_i),
        .rst_i          (rst_i),
        .boot_profile_i (boot_profile_i),
        .nv_valid_i     (nv_valid_i),
        .nv_req_o       (nv_req_o),
        .nv_profile_o   (nv_profile_o),
        .nv_index_o     (nv_index_o),
        .wr_en_o        (ld_wr),
        .busy_o         (ld_busy)
    );

    // ----------------------------------------------------------------
    // Applying sets to acquisitions
    // ----------------------------------------------------------------
    assign eff_shade = (cyc_en_q && incl_q[apss_pkg::APSS_KIND_SHADE]) ? a_shade : live_shade_q;
    assign eff_gain  = (cyc_en_q && incl_q[apss_pkg::APSS_KIND_GAIN]) ? a_gain : live_gain_q;
    assign eff_exp   = (cyc_en_q && incl_q[apss_pkg::APSS_KIND_EXP]) ? a_exp : live_exp_q;

    // Shading and gain are staged at exposure start so that one acquisition
    // never mixes values from two different sets.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            exposure_o   <= EXP_W'(`APSS_DEF_EXP);
            pend_shade_q <= SHADE_W'(`APSS_DEF_SHADE);
            pend_gain_q  <= GAIN_W'(`APSS_DEF_GAIN);
        end else if (exposure_start_i) begin
            exposure_o   <= eff_exp;
            pend_shade_q <= eff_shade;
            pend_gain_q  <= eff_gain;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shading_o <= SHADE_W'(`APSS_DEF_SHADE);
            gain_o    <= GAIN_W'(`APSS_DEF_GAIN);
        end else if (frame_req_i) begin
            shading_o <= pend_shade_q;
            gain_o    <= pend_gain_q;
        end
    end

    // Restart wins over an advance in the same cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            live_index_o <= '0;
        end else if (restart_go) begin
            live_index_o <= '0;
        end else if (frame_req_i && cyc_en_q) begin
            if (LEN_W'(live_index_o) + LEN_W'(`APSS_LEN_MIN) >= len_q) begin
                live_index_o <= '0;
            end else begin
                live_index_o <= live_index_o + IDX_W'(1);
            end
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_RESTART_ZERO: assert property (restart_go |=> live_index_o == '0)
        else $error("restart did not return live index to zero");
    AST_WRAP: assert property (frame_req_i && cyc_en_q && !restart_go
        && LEN_W'(live_index_o) == len_q - LEN_W'(1) |=> live_index_o == '0)
        else $error("live index did not wrap after last set");
    AST_ADVANCE: assert property (frame_req_i && cyc_en_q && !restart_go
        && LEN_W'(live_index_o) < len_q - LEN_W'(1) |=> live_index_o == $past(live_index_o) + IDX_W'(1))
        else $error("live index did not advance");
    AST_HOLD_OFF: assert property (!cyc_en_q && !restart_go |=> $stable(live_index_o))
        else $error("live index moved while cycling is off");
    AST_LEN_LEGAL: assert property (len_q >= LEN_W'(`APSS_LEN_MIN) && len_q <= LEN_W'(SETS))
        else $error("cycle length out of range");
    AST_EDIT_DEFAULTS: assert property (edit_enter && !ld_busy |=> incl_q == `APSS_INCL_ALL
        && b_gain == GAIN_W'(`APSS_DEF_GAIN) && b_exp == EXP_W'(`APSS_DEF_EXP))
        else $error("edit entry did not load defaults");
    AST_EDIT_STORE: assert property (wr_at(`APSS_OFF_GAIN) && edit_q && incl_q[apss_pkg::APSS_KIND_GAIN]
        && !ld_busy |=> b_gain == $past(wval[GAIN_W-1:0]) && $stable(live_gain_q))
        else $error("edit write did not reach the selected set");
    AST_EXP_AT_START: assert property (exposure_start_i |=> exposure_o == $past(eff_exp))
        else $error("integration period not applied at exposure start");
    AST_GAIN_AT_FRAME: assert property (!frame_req_i |=> $stable(gain_o) && $stable(shading_o))
        else $error("gain or shading changed outside a frame request");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    COV_WRAP: cover property (frame_req_i && cyc_en_q && live_index_o != '0 ##1 live_index_o == '0);
    COV_RESTART: cover property (cyc_en_q && live_index_o != '0 ##1 restart_go);
    COV_EDIT: cover property (edit_enter ##[1:50] st_en);

endmodule

// ===== tb/test_acquisition_parameter_set_sequencer.sv
`include "apss_map.svh"

module test_acquisition_parameter_set_sequencer;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        req   = 1'b0;
    logic        we    = 1'b0;
    logic        es    = 1'b0;
    logic        fr    = 1'b0;
    logic        nvv   = 1'b0;
    logic [7:0]  adr   = 8'h00;
    logic [31:0] wdat  = 32'h0000_0000;
    logic [31:0] rd;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        nv_req_o;
    logic [4:0]  nv_index_o;
    logic [1:0]  nv_profile_o;
    logic [4:0]  live_index_o;
    logic [3:0]  shading_o;
    logic [7:0]  gain_o;
    logic [23:0] exposure_o;
    int          err_total = 0;
    int          checks    = 0;

    apss_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .exposure_start_i(es), .frame_req_i(fr), .boot_profile_i(2'h2), .nv_valid_i(nvv),
        .nv_shade_i(nv_index_o[3:0]), .nv_gain_i({3'h0, nv_index_o} + 8'h01),
        .nv_exp_i({19'h0_0000, nv_index_o} + 24'h00_0100), .nv_req_o(nv_req_o), .nv_profile_o(nv_profile_o),
        .nv_index_o(nv_index_o), .shading_o(shading_o), .gain_o(gain_o), .exposure_o(exposure_o),
        .live_index_o(live_index_o));

    always #12.5 clk_i = ~clk_i;

    // The store answers every request with one valid pulse, then a gap cycle.
    always @(posedge clk_i) nvv <= nv_req_o & ~nvv;

    task automatic conclude;
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        checks++;
        if (got !== want) begin
            err_total++;
            $display("BAD %0t got %h want %h", $time, got, want);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        req  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        req <= 1'b0;
        if (wb_ack_o !== 1'b1) begin
            err_total++;
            conclude();
        end
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] want);
        bus(1'b0, a, 32'h0000_0000);
        chk(rd, want);
    endtask

    // One acquisition: live set i, expected applied values, live set afterwards.
    task automatic acq(input logic [31:0] i, input logic [31:0] s, input logic [31:0] g,
                       input logic [31:0] e, input logic [31:0] nxt);
        chk({27'h0, live_index_o}, i);
        @(posedge clk_i) es <= 1'b1;
        @(posedge clk_i) es <= 1'b0;
        #1 chk({8'h00, exposure_o}, e);
        @(posedge clk_i) fr <= 1'b1;
        @(posedge clk_i) fr <= 1'b0;
        #1 chk({28'h0, shading_o}, s);
        chk({24'h00, gain_o}, g);
        chk({27'h0, live_index_o}, nxt);
    endtask

    initial begin
        repeat (100000) @(posedge clk_i);
        err_total++;
        conclude();
    end

    initial begin
        int n;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(`APSS_OFF_CTRL, 32'h0000_0000);
        rdc(`APSS_OFF_LEN, 32'h0000_0020);
        rdc(`APSS_OFF_PROFILE, 32'h0000_0002);
        rdc(8'h3C, 32'h0000_0000);
        for (n = 0; n < 500 && nv_req_o !== 1'b0; n++) @(posedge clk_i);
        chk({31'h0, nv_req_o}, 32'h0000_0000);
        chk({30'h0, nv_profile_o}, 32'h0000_0002);
        acq(0, 0, 1, 32'h0000_2710, 0);
        bus(1'b1, `APSS_OFF_CTRL, 32'h0000_0001);
        bus(1'b1, `APSS_OFF_LEN, 32'h0000_0003);
        for (n = 0; n < 4; n++) acq(n % 3, n % 3, n % 3 + 1, n % 3 + 256, (n + 1) % 3);
        bus(1'b1, `APSS_OFF_RESTART, 32'h0000_0001);
        rdc(`APSS_OFF_LIVE_IDX, 32'h0000_0000);
        bus(1'b1, `APSS_OFF_LIVE_IDX, 32'h0000_0003);
        rdc(`APSS_OFF_LIVE_IDX, 32'h0000_0000);
        bus(1'b1, `APSS_OFF_CTRL, 32'h0000_0000);
        bus(1'b1, `APSS_OFF_EDIT_IDX, 32'h0000_0005);
        bus(1'b1, `APSS_OFF_CTRL, 32'h0000_0002);
        rdc(`APSS_OFF_INCL, 32'h0000_0001);
        rdc(`APSS_OFF_SHADE, 32'h0000_0000);
        rdc(`APSS_OFF_GAIN, 32'h0000_0001);
        rdc(`APSS_OFF_EXP, 32'h0000_2710);
        bus(1'b1, `APSS_OFF_SHADE, 32'h0000_0007);
        bus(1'b1, `APSS_OFF_GAIN, 32'h0000_0044);
        rdc(`APSS_OFF_GAIN, 32'h0000_0044);
        bus(1'b1, `APSS_OFF_EXP, 32'h0000_3039);
        rdc(`APSS_OFF_EXP, 32'h0000_3039);
        bus(1'b1, `APSS_OFF_CTRL, 32'h0000_0000);
        bus(1'b1, `APSS_OFF_PICK, 32'h0000_0001);
        bus(1'b1, `APSS_OFF_PICK, 32'h0000_0003);
        rdc(`APSS_OFF_PICK, 32'h0000_0001);
        bus(1'b1, `APSS_OFF_INCL, 32'h0000_0000);
        rdc(`APSS_OFF_INCL, 32'h0000_0000);
        bus(1'b1, `APSS_OFF_GAIN, 32'h0000_0022);
        bus(1'b1, `APSS_OFF_LEN, 32'h0000_0006);
        bus(1'b1, `APSS_OFF_LEN, 32'h0000_0021);
        rdc(`APSS_OFF_LEN, 32'h0000_0006);
        bus(1'b1, `APSS_OFF_LEN, 32'h0000_0000);
        rdc(`APSS_OFF_LEN, 32'h0000_0006);
        bus(1'b1, `APSS_OFF_CTRL, 32'h0000_0001);
        for (n = 0; n < 6; n++)
            acq(n, n == 5 ? 7 : n, 32'h22, n == 5 ? 32'h3039 : n + 256, (n + 1) % 6);
        conclude();
    end
endmodule
